/* hw/irc_pkg.sv */
// Constants for the remote carrier timer and port control block
package irc_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] KEY_PORT_OFS  = 4'h1;
    localparam logic [3:0] TCC_OFS       = 4'h3;
    localparam logic [3:0] PMC_OFS       = 4'h4;
    localparam logic [3:0] TLOAD_LO_OFS  = 4'h5;
    localparam logic [3:0] TLOAD_HI_OFS  = 4'h6;
    // ----------------------------------------------------------------
    // Reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [7:0] TCC_RESET     = 8'h03;
    localparam logic [7:0] PMC_RESET     = 8'h26;
    localparam logic [7:0] TCC_MASK      = 8'h3f;
    localparam logic [7:0] PMC_MASK      = 8'h37;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CAR_SEL_LO            = 0;
    localparam int CAR_DIS_BIT           = 2;
    localparam int HALVE_BIT             = 3;
    localparam int PTR_LO_BIT            = 4;
    localparam int SENSE_MODE_BIT        = 0;
    localparam int SCAN_MODE_BIT         = 1;
    localparam int IND_MODE_BIT          = 2;
    localparam int SENSE_PD_BIT          = 4;
    localparam int KEY_PD_BIT            = 5;
    localparam int KP_SENSE_BIT          = 2;
    localparam int KP_IND_BIT            = 3;
    localparam int KP_KEY_LO             = 4;
    localparam int TSTAT_RUN_BIT         = 7;
    localparam int TSTAT_OE_BIT          = 1;
    // ----------------------------------------------------------------
    // Timing: TIMER_HALF and the carrier periods counted in half periods of fx
    // ----------------------------------------------------------------
    localparam int CLK_MHZ               = 125;
    localparam int CLK_PERIOD_NS         = 8;
    localparam int TIMER_FX_CYCLES       = 8;
    localparam logic [5:0] TIMER_HALF    = 6'(2 * TIMER_FX_CYCLES);
    localparam logic [5:0] CAR_P_FX      = 6'h02;
    localparam logic [5:0] CAR_H_FX      = 6'h01;
    localparam logic [5:0] CAR_P_DIV8    = 6'h10;
    localparam logic [5:0] CAR_H_DIV8    = 6'h08;
    localparam logic [5:0] CAR_P_DIV12   = 6'h18;
    localparam logic [5:0] CAR_H_DIV12   = 6'h0c;
    localparam logic [5:0] CAR_H_THIRD   = 6'h08;
    // ----------------------------------------------------------------
    // Timer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TS_IDLE = 2'b01,
        TS_RUN  = 2'b10
    } irc_tstate_e;
endpackage

/* hw/irc_timer_port.sv */
// Remote carrier timer, port mode control and key/sense input port
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
// Function
// - Port bit 2 reads sense pin in input mode, 1 in off mode.
// - Port bit 3 reads indicator pin level in any mode.
// - Port bits 7:4 read key pins; bits 1:0 read 1.
// - Mode bit 0 selects sense input or off; reset is off.
// - Bit 4 enables sense/indicator pull-downs in input mode only.
// - Bit 5 enables all four key-input pull-downs.
// - Pins in output or off mode lose their pull-downs.
// - Bit 2 makes indicator pin input or output; reset drives high.
// - Bit 1 sets the eight key-scan pins input or output.
// - Control bits 1:0 choose carrier frequency and duty.
// - Control bit 2 suppresses carrier, giving plain high.
// - Control bit 3 halves timer clock and every carrier.
// - Control bits 5:4 give pointer bits eight and nine.
// - Timer has 9-bit down counter, output flag, zero detect.
// - Loading a nonzero count starts the timer.
// - Count drops each period, stops at zero, end held.
// - A halt waiting on the timer is released at zero.
// - Interval is loaded count plus one periods.
// - With flag set, indicator low and remote outputs carrier (plain high with bit 2) while counting.
// - Carrier stopping mid-high finishes its high phase first.
// - First carrier high phase after start may be short.
// - Rewriting the flag on back-to-back writes gives short pulses.
module irc_timer_port #(
    parameter int FX_HALF_DIV = 1
) (
    input  wire logic       sys_clk_in,
    input  wire logic       resetn_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    input  wire logic [3:0] key_input_pins_in,
    input  wire logic       sense_input_pin_in,
    output logic            sense_input_en_out,
    output logic            sense_pd_out,
    output logic            key_input_pd_out,
    input  wire logic       indicator_sense_pin_in,
    output logic            indicator_sense_pin_out,
    output logic            indicator_sense_pin_oe_out,
    output logic            indicator_pd_out,
    output logic      [7:0] key_scan_oe_out,
    output logic            key_scan_pd_out,
    output logic            remote_output_pin_out,
    output logic      [1:0] pointer_high_out,
    input  wire logic       halt_timer_wait_in,
    output logic            halt_release_out,
    output logic            timer_end_out
);

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [7:0]  tcc_reg;
    logic [7:0]  pmc_reg;
    logic [7:0]  tload_lo_reg;
    logic [8:0]  cnt_reg;
    logic        oe_flag_reg;
    irc_pkg::irc_tstate_e tstate_reg;
    logic        key_s1_reg [4];
    logic [3:0]  key_s2_reg;
    logic        sense_s1_reg;
    logic        sense_s2_reg;
    logic        ind_s1_reg;
    logic        ind_s2_reg;
    logic [7:0]  rdata_reg;
    logic        rem_out_reg;
    logic        rem_active_reg;
    logic        ind_out_reg;
    logic        release_reg;
    logic [15:0] half_div_reg;
    logic [5:0]  tpre_reg;
    logic [5:0]  car_cnt_reg;

    logic        half_tick;
    logic        timer_tick;
    logic        load_cmd;
    logic        halve;
    logic        car_dis;
    logic        carrier_hi;
    logic [5:0]  car_period;
    logic [5:0]  car_high;
    logic [5:0]  tpre_last;
    logic        running;
    logic [7:0]  key_port;

    assign halve     = tcc_reg[irc_pkg::HALVE_BIT];
    assign car_dis   = tcc_reg[irc_pkg::CAR_DIS_BIT];
    assign running   = (tstate_reg == irc_pkg::TS_RUN);
    assign load_cmd  = wr_in && (addr_in == irc_pkg::TLOAD_HI_OFS);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_key_sync
            always_ff @(posedge sys_clk_in) begin
                key_s1_reg[gi] <= key_input_pins_in[gi];
                key_s2_reg[gi] <= key_s1_reg[gi];
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in) begin
        sense_s1_reg <= sense_input_pin_in;
        sense_s2_reg <= sense_s1_reg;
        ind_s1_reg   <= indicator_sense_pin_in;
        ind_s2_reg   <= ind_s1_reg;
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            tcc_reg <= irc_pkg::TCC_RESET;
        end else if (wr_in && addr_in == irc_pkg::TCC_OFS) begin
            tcc_reg <= wdata_in & irc_pkg::TCC_MASK;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            pmc_reg <= irc_pkg::PMC_RESET;
        end else if (wr_in && addr_in == irc_pkg::PMC_OFS) begin
            pmc_reg <= wdata_in & irc_pkg::PMC_MASK;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            tload_lo_reg <= 8'h00;
        end else if (wr_in && addr_in == irc_pkg::TLOAD_LO_OFS) begin
            tload_lo_reg <= wdata_in;
        end
    end

    // ------------------------------------------------------------
    // Port modes and pull-downs
    // ------------------------------------------------------------
    // Pull-downs only ever connect to pins that are listening
    assign sense_input_en_out = pmc_reg[irc_pkg::SENSE_MODE_BIT];
    assign sense_pd_out = pmc_reg[irc_pkg::SENSE_PD_BIT]
                        & pmc_reg[irc_pkg::SENSE_MODE_BIT];
    assign indicator_pd_out = pmc_reg[irc_pkg::SENSE_PD_BIT]
                            & ~pmc_reg[irc_pkg::IND_MODE_BIT];
    assign key_input_pd_out = pmc_reg[irc_pkg::KEY_PD_BIT];
    assign key_scan_oe_out  = {8{pmc_reg[irc_pkg::SCAN_MODE_BIT]}};
    assign key_scan_pd_out  = ~pmc_reg[irc_pkg::SCAN_MODE_BIT];
    assign indicator_sense_pin_oe_out = pmc_reg[irc_pkg::IND_MODE_BIT];
    assign pointer_high_out = tcc_reg[irc_pkg::PTR_LO_BIT +: 2];

    // ------------------------------------------------------------
    // Key/special input port and read data
    // ------------------------------------------------------------
    always_comb begin
        key_port = 8'h03;
        key_port[irc_pkg::KP_KEY_LO +: 4] = key_s2_reg;
        key_port[irc_pkg::KP_IND_BIT] = ind_s2_reg;
        key_port[irc_pkg::KP_SENSE_BIT] =
            pmc_reg[irc_pkg::SENSE_MODE_BIT] ? sense_s2_reg : 1'b1;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rdata_reg <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                irc_pkg::KEY_PORT_OFS: rdata_reg <= key_port;
                irc_pkg::TCC_OFS:      rdata_reg <= tcc_reg;
                irc_pkg::PMC_OFS:      rdata_reg <= pmc_reg;
                irc_pkg::TLOAD_LO_OFS: rdata_reg <= cnt_reg[7:0];
                irc_pkg::TLOAD_HI_OFS: rdata_reg <=
                    {running, 5'h00, oe_flag_reg, cnt_reg[8]};
                default:               rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign rdata_out = rdata_reg;

    // ------------------------------------------------------------
    // Time base: half periods of fx
    // ------------------------------------------------------------
    assign half_tick = (half_div_reg == 16'(FX_HALF_DIV - 1));

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || half_tick) begin
            half_div_reg <= 16'h0000;
        end else begin
            half_div_reg <= half_div_reg + 16'h0001;
        end
    end

    // Prescaler restarts on every load so the first period is whole
    assign tpre_last = halve ? 6'((irc_pkg::TIMER_HALF << 1) - 6'h01)
                             : 6'(irc_pkg::TIMER_HALF - 6'h01);
    assign timer_tick = half_tick && (tpre_reg >= tpre_last);

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || load_cmd || timer_tick) begin
            tpre_reg <= 6'h00;
        end else if (half_tick) begin
            tpre_reg <= tpre_reg + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // Down counter and timer state
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            oe_flag_reg <= 1'b0;
        end else if (load_cmd) begin
            oe_flag_reg <= wdata_in[irc_pkg::TSTAT_OE_BIT];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            cnt_reg    <= 9'h000;
            tstate_reg <= irc_pkg::TS_IDLE;
        end else if (load_cmd) begin
            cnt_reg <= {wdata_in[0], tload_lo_reg};
            if ({wdata_in[0], tload_lo_reg} != 9'h000) begin
                tstate_reg <= irc_pkg::TS_RUN;
            end else begin
                tstate_reg <= irc_pkg::TS_IDLE;
            end
        end else begin
            case (tstate_reg)
                irc_pkg::TS_IDLE: tstate_reg <= irc_pkg::TS_IDLE;
                irc_pkg::TS_RUN: begin
                    // Zero is held for one more period: count + 1 in all
                    if (timer_tick && cnt_reg == 9'h000) begin
                        tstate_reg <= irc_pkg::TS_IDLE;
                    end else if (timer_tick) begin
                        cnt_reg <= cnt_reg - 9'h001;
                    end
                end
                default: begin
                    tstate_reg <= irc_pkg::TS_IDLE;
                end
            endcase
        end
    end

    assign timer_end_out = !running && (cnt_reg == 9'h000);

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            release_reg <= 1'b0;
        end else begin
            release_reg <= halt_timer_wait_in && running && !load_cmd
                        && timer_tick && (cnt_reg == 9'h000);
        end
    end

    assign halt_release_out = release_reg;

    // ------------------------------------------------------------
    // Carrier generator
    // ------------------------------------------------------------
    // Free running, so the first high phase after a start may be cut
    always_comb begin
        case (tcc_reg[irc_pkg::CAR_SEL_LO +: 2])
            2'b00: begin
                car_period = irc_pkg::CAR_P_FX;
                car_high   = irc_pkg::CAR_H_FX;
            end
            2'b01: begin
                car_period = irc_pkg::CAR_P_DIV8;
                car_high   = irc_pkg::CAR_H_DIV8;
            end
            2'b10: begin
                car_period = irc_pkg::CAR_P_DIV12;
                car_high   = irc_pkg::CAR_H_DIV12;
            end
            default: begin
                car_period = irc_pkg::CAR_P_DIV12;
                car_high   = irc_pkg::CAR_H_THIRD;
            end
        endcase
        if (halve) begin
            car_period = car_period << 1;
            car_high   = car_high << 1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            car_cnt_reg <= 6'h00;
        end else if (half_tick) begin
            if (car_cnt_reg >= car_period - 6'h01) begin
                car_cnt_reg <= 6'h00;
            end else begin
                car_cnt_reg <= car_cnt_reg + 6'h01;
            end
        end
    end

    assign carrier_hi = (car_cnt_reg < car_high);

    // ------------------------------------------------------------
    // Remote and indicator outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rem_active_reg <= 1'b0;
        end else begin
            rem_active_reg <= running
                | (rem_active_reg & ~car_dis & carrier_hi);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rem_out_reg <= 1'b0;
        end else begin
            // A plain high level stops with the timer; only a carrier gets a tail
            rem_out_reg <= oe_flag_reg & (running | (rem_active_reg & ~car_dis))
                & (car_dis | carrier_hi);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            ind_out_reg <= 1'b1;
        end else begin
            ind_out_reg <= ~(oe_flag_reg & running);
        end
    end

    assign remote_output_pin_out   = rem_out_reg;
    assign indicator_sense_pin_out = ind_out_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_last_tick;
        running && timer_tick && cnt_reg == 9'h000 && !load_cmd;
    endsequence

    sequence s_mid_tick;
        running && timer_tick && cnt_reg != 9'h000 && !load_cmd;
    endsequence

    a_key_fixed_ones: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        rd_in && addr_in == irc_pkg::KEY_PORT_OFS |=> rdata_out[1:0] == 2'b11)
        else $error("key port fixed bits not one");

    a_sense_off_read: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        rd_in && addr_in == irc_pkg::KEY_PORT_OFS && !sense_input_en_out
        |=> rdata_out[2])
        else $error("sense bit not one in off mode");

    a_pd_gating: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        (sense_pd_out |-> sense_input_en_out)
        and (indicator_pd_out |-> !indicator_sense_pin_oe_out))
        else $error("pull-down on a pin not in input mode");

    a_load_starts: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        load_cmd && {wdata_in[0], tload_lo_reg} != 9'h000
        |=> running && !timer_end_out)
        else $error("nonzero load did not start timer");

    a_count_step: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        s_mid_tick |=> running && cnt_reg == $past(cnt_reg) - 9'h001)
        else $error("counter did not step by one");

    a_stop_zero: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        s_last_tick |=> timer_end_out [*3])
        else $error("timer did not stop at zero");

    a_halt_release: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        s_last_tick ##0 halt_timer_wait_in |=> halt_release_out)
        else $error("halt not released at zero");

    a_rem_stopped: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $fell(running) && car_dis |=> !remote_output_pin_out)
        else $error("remote output high while stopped");

    a_ind_running: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        running && oe_flag_reg |=> !indicator_sense_pin_out)
        else $error("indicator not low while counting");

    a_carrier_tail: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        rem_active_reg && !running && carrier_hi && !car_dis && oe_flag_reg
        |=> remote_output_pin_out)
        else $error("carrier cut during high phase");

endmodule

/* tb/irc_far_side.sv */
// Far-side model: key matrix, sense switches and indicator pin wiring
`timescale 1ns/1ns
module irc_far_side (
    input  wire logic       sys_clk_in,
    input  wire logic       resetn_in,
    input  wire logic [3:0] press_in,
    input  wire logic       sense_sw_in,
    input  wire logic       ind_sw_in,
    input  wire logic       key_pd_in,
    input  wire logic       sense_en_in,
    input  wire logic       sense_pd_in,
    input  wire logic       ind_drive_in,
    input  wire logic       ind_oe_in,
    input  wire logic       ind_pd_in,
    output logic      [3:0] key_pins_out,
    output logic            sense_pin_out,
    output logic            ind_pin_out
);
    // ----------------------------------------------------------------
    // Floating lines
    // ----------------------------------------------------------------
    // An undriven line toggles every cycle so a stale value never reads as valid
    logic flip_reg;

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            flip_reg <= 1'b0;
        end else begin
            flip_reg <= ~flip_reg;
        end
    end

    // ----------------------------------------------------------------
    // Pin levels
    // ----------------------------------------------------------------
    // Keys all held low through reset
    assign key_pins_out = resetn_in ? (press_in | (key_pd_in ? 4'h0 : {4{flip_reg}}))
                                    : 4'h0;
    assign sense_pin_out = sense_en_in ? (sense_sw_in | (~sense_pd_in & flip_reg)) : flip_reg;
    assign ind_pin_out = ind_oe_in ? ind_drive_in : (ind_sw_in | (~ind_pd_in & flip_reg));
endmodule

/* tb/tb.sv */
// Self-checking bench for the remote carrier timer and port control block
`timescale 1ns/1ns
module tb;
    logic       clk;
    logic       rstn;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd_s;
    logic       halt_wait;
    logic [3:0] press;
    logic       sense_sw;
    logic       ind_sw;
    logic [7:0] rdata;
    logic [3:0] key_pins;
    logic       sense_pin, sense_en, sense_pd, key_pd;
    logic       ind_pin, ind_out, ind_oe, ind_pd;
    logic [7:0] scan_oe;
    logic       scan_pd, remote, release_p, tend;
    logic [1:0] ptr;
    int         err_count, comparisons, cycles, m_pmc, n;
    int         hi_t[4] = '{1, 8, 12, 8};
    int         lo_t[4] = '{1, 8, 12, 16};

    irc_timer_port #(.FX_HALF_DIV(1)) DUT (.sys_clk_in(clk), .resetn_in(rstn),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd_s), .rdata_out(rdata),
        .key_input_pins_in(key_pins), .sense_input_pin_in(sense_pin),
        .sense_input_en_out(sense_en), .sense_pd_out(sense_pd), .key_input_pd_out(key_pd),
        .indicator_sense_pin_in(ind_pin), .indicator_sense_pin_out(ind_out),
        .indicator_sense_pin_oe_out(ind_oe), .indicator_pd_out(ind_pd),
        .key_scan_oe_out(scan_oe), .key_scan_pd_out(scan_pd), .remote_output_pin_out(remote),
        .pointer_high_out(ptr), .halt_timer_wait_in(halt_wait),
        .halt_release_out(release_p), .timer_end_out(tend));

    irc_far_side far (.sys_clk_in(clk), .resetn_in(rstn), .press_in(press),
        .sense_sw_in(sense_sw), .ind_sw_in(ind_sw), .key_pd_in(key_pd),
        .sense_en_in(sense_en), .sense_pd_in(sense_pd), .ind_drive_in(ind_out),
        .ind_oe_in(ind_oe), .ind_pd_in(ind_pd), .key_pins_out(key_pins),
        .sense_pin_out(sense_pin), .ind_pin_out(ind_pin));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard sized well above the longest expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pins(input logic [7:0] p);
        chk({sense_en, sense_pd, key_pd, ind_oe, ind_pd, scan_pd, scan_oe, 2'b00},
            {p[0], p[0] & p[4], p[5], p[2], p[4] & ~p[2], ~p[1], {8{p[1]}}, 2'b00});
    endtask

    function automatic logic [7:0] kport(input logic ind);
        kport = {press, ind, m_pmc[0] ? sense_sw : 1'b1, 2'b11};
    endfunction

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk({8'h00, rdata}, {8'h00, e});
    endtask

    task automatic load(input logic [8:0] c, input logic flag);
        wr_reg(4'h5, c[7:0]);
        wr_reg(4'h6, {6'h00, flag, c[8]});
    endtask

    // Counts the cycles with the end signal low, starting just after the commit edge
    task automatic run_time(input int exp_len, input logic flag, input logic hw);
        int len;
        int rel;
        len = 0;
        rel = 0;
        #1;
        while (tend === 1'b0 && len < 9000) begin
            if (len == 4) chk({14'h0, remote, ind_out}, {14'h0, flag, ~flag});
            len++;
            @(posedge clk);
            #1;
            rel += release_p;
        end
        repeat (3) begin
            @(posedge clk);
            #1;
            rel += release_p;
        end
        chk(16'(len), 16'(exp_len));
        chk(16'(rel), {15'h0, hw});
        chk({13'h0, remote, ind_out, tend}, 16'h3);
    endtask

    // Every whole carrier phase, the tail one included, has its programmed width
    task automatic run_carrier(input int hi, input int lo);
        int   run;
        int   edges;
        logic prev;
        run = 0;
        edges = 0;
        prev = 1'b0;
        for (int g = 0; g < 4000; g++) begin
            @(posedge clk);
            #1;
            if (remote !== prev) begin
                if (edges > 1) chk(16'(run), 16'(prev ? hi : lo));
                edges++;
                run = 0;
            end
            run++;
            prev = remote;
            if (tend === 1'b1 && run > 64) break;
        end
        chk({14'h0, edges > 4, remote}, 16'h2);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd_s = 1'b0;
        halt_wait = 1'b0;
        press = 4'h0;
        sense_sw = 1'b0;
        ind_sw = 1'b0;
        void'($urandom(32'h7a65));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        press <= 4'($urandom);
        m_pmc = 8'h26;
        rd_reg(4'h3, 8'h03);
        rd_reg(4'h4, 8'h26);
        rd_reg(4'h0, 8'h00);
        chk_pins(8'h26);
        chk({11'h0, ind_out, remote, tend, ptr}, 16'h0014);
        rd_reg(4'h1, kport(1'b1));
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            n = $urandom;
            wr_reg(4'h4, n[7:0]);
            m_pmc = n & 8'h37;
            rd_reg(4'h4, 8'(m_pmc));
            chk_pins(8'(m_pmc));
            m_pmc = m_pmc | 8'h30;
            wr_reg(4'h4, 8'(m_pmc));
            press <= 4'($urandom);
            sense_sw <= 1'($urandom);
            ind_sw <= 1'($urandom);
            repeat (4) @(posedge clk);
            rd_reg(4'h1, kport(m_pmc[2] ? 1'b1 : ind_sw));
        end
        m_pmc = 8'h26;
        wr_reg(4'h4, 8'h26);
        $display("test port modes done");
        for (int i = 0; i < 4; i++) begin
            n = $urandom;
            wr_reg(4'h3, n[7:0]);
            rd_reg(4'h3, n[7:0] & 8'h3f);
            chk({14'h0, ptr}, {14'h0, n[5:4]});
        end
        $display("test control register done");
        @(posedge clk) halt_wait <= 1'b1;
        for (int h = 0; h < 2; h++) begin
            wr_reg(4'h3, h ? 8'h0c : 8'h04);
            n = h ? 1 + $urandom % 30 : 9'h101;
            load(9'(n), 1'b1);
            run_time((n + 1) * 16 * (h + 1), 1'b1, 1'b1);
        end
        @(posedge clk) halt_wait <= 1'b0;
        load(9'd0, 1'b0);
        repeat (3) @(posedge clk);
        #1 chk({14'h0, tend, remote}, 16'h2);
        load(9'd50, 1'b1);
        rd_reg(4'h6, 8'h82);
        rd_reg(4'h1, kport(1'b0));
        wr_reg(4'h6, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk({15'h0, remote}, 16'h0);
        wr_reg(4'h6, 8'h02);
        repeat (2) @(posedge clk);
        #1 chk({15'h0, remote}, 16'h1);
        load(9'd3, 1'b0);
        run_time(4 * 32, 1'b0, 1'b0);
        $display("test timer done");
        for (int m = 0; m < 8; m++) begin
            wr_reg(4'h3, {4'h0, m[2], 1'b0, m[1:0]});
            load(9'd40, 1'b1);
            run_carrier(hi_t[m[1:0]] * (1 + m[2]), lo_t[m[1:0]] * (1 + m[2]));
        end
        $display("test carrier done");
        report_and_stop();
    end
endmodule
